// *** pkg/ppcs_pkg.sv ***
// Constants and types shared by the page port design
package ppcs_pkg;

	localparam int unsigned PPCS_ADDR_W     = 3;
	localparam int unsigned PPCS_PORT_W     = 8;
	localparam int unsigned PPCS_PAGE_W     = 6;

	// Register offsets
	localparam logic [2:0] PPCS_OFS_DATA    = 3'h0;
	localparam logic [2:0] PPCS_OFS_DIR     = 3'h1;
	localparam logic [2:0] PPCS_OFS_PULL    = 3'h2;
	localparam logic [2:0] PPCS_OFS_BUSCTL  = 3'h3;
	localparam logic [2:0] PPCS_OFS_MODE    = 3'h4;

	// Field positions
	localparam int unsigned PPCS_BIT_PULL_EN    = 7;
	localparam int unsigned PPCS_BIT_STRETCH    = 0;
	localparam int unsigned PPCS_BIT_EMU_EN     = 7;
	localparam int unsigned PPCS_BIT_EXPANDED   = 0;
	localparam int unsigned PPCS_BIT_ECS        = 7;
	localparam int unsigned PPCS_BIT_XCS        = 6;

	// Reset values
	localparam logic [7:0] PPCS_RST_DATA    = 8'h00;
	localparam logic [7:0] PPCS_RST_DIR     = 8'h00;
	localparam logic       PPCS_RST_PULL_EN = 1'h0;
	localparam logic       PPCS_RST_STRETCH = 1'h1;
	localparam logic       PPCS_RST_EMU_EN  = 1'h0;
	localparam logic       PPCS_RST_EXPAND  = 1'h0;

	// Timing: bus phase clock period and the chip select gap
	localparam int unsigned PPCS_CORE_PERIOD_NS  = 10;
	localparam int unsigned PPCS_E_PERIOD_NS     = 40;
	localparam int unsigned PPCS_E_PERIOD_CYCLES = PPCS_E_PERIOD_NS / PPCS_CORE_PERIOD_NS;
	localparam int unsigned PPCS_CS_GAP_CYCLES   = PPCS_E_PERIOD_CYCLES / 4;

	// One state per quarter of the bus phase clock
	typedef enum logic [1:0] {
		PPCS_PH_LOW0  = 2'b00,
		PPCS_PH_LOW1  = 2'b01,
		PPCS_PH_HIGH0 = 2'b10,
		PPCS_PH_HIGH1 = 2'b11
	} ppcs_phase_type;

endpackage

// *** hw/ppcs_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module ppcs_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             CORE_CLK,
	input  wire logic             RST_B,
	input  wire logic [WIDTH-1:0] ASYNC_IN,
	output logic      [WIDTH-1:0] SYNC_OUT
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
		logic [WIDTH-1:0] stage3;
		logic [WIDTH-1:0] level;
	} ppcs_sync_type;

	ppcs_sync_type state;
	ppcs_sync_type next_state;

	always_comb begin
		next_state        = state;
		next_state.stage1 = ASYNC_IN;
		next_state.stage2 = state.stage1;
		next_state.stage3 = state.stage2;
		// Only a change seen twice in a row is taken
		for (int i = 0; i < WIDTH; i++) begin
			if (state.stage2[i] == state.stage3[i]) begin
				next_state.level[i] = state.stage3[i];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign SYNC_OUT = state.level;

endmodule

// *** hw/ppcs_port.sv ***
// Page port with chip selects: GPIO, page address and chip select outputs
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module ppcs_port (
	input  wire logic                             CORE_CLK,
	input  wire logic                             RST_B,
	input  wire logic [ppcs_pkg::PPCS_ADDR_W-1:0] ADDR,
	input  wire logic [7:0]                       WDATA,
	input  wire logic                             WR,
	input  wire logic                             RD,
	output logic      [7:0]                       RDATA,
	input  wire logic [ppcs_pkg::PPCS_PORT_W-1:0] PIN_IN,
	output logic      [ppcs_pkg::PPCS_PORT_W-1:0] PIN_OUT,
	output logic      [ppcs_pkg::PPCS_PORT_W-1:0] PIN_OE,
	output logic      [ppcs_pkg::PPCS_PORT_W-1:0] PIN_PULL,
	input  wire logic [ppcs_pkg::PPCS_PAGE_W-1:0] EXPANDED_PAGE_ADDRESS_BITS,
	input  wire logic                             EMULATION_CHIP_SELECT_REQ,
	input  wire logic                             EXTERNAL_CHIP_SELECT_REQ,
	input  wire logic                             STRETCH_REQ,
	output logic                                  BUS_PHASE_CLOCK,
	output logic                                  ECHO_WR,
	output logic                                  ECHO_RD,
	output logic      [ppcs_pkg::PPCS_ADDR_W-1:0] ECHO_ADDR,
	output logic      [7:0]                       ECHO_WDATA
);

	import ppcs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [7:0]             page_port_data;
		logic [7:0]             page_port_direction;
		logic                   page_port_pull_enable;
		logic                   e_stretch_enable;
		logic                   page_emulation_enable;
		logic                   expanded_mode;
		ppcs_phase_type         phase;
		logic                   e_clk;
		logic [7:0]             rdata;
		logic [7:0]             pin_out;
		logic [7:0]             pin_oe;
		logic [7:0]             pin_pull;
		logic                   echo_wr;
		logic                   echo_rd;
		logic [PPCS_ADDR_W-1:0] echo_addr;
		logic [7:0]             echo_wdata;
	} ppcs_state_type;

	ppcs_state_type state;
	ppcs_state_type next_state;

	logic [7:0] pin_level;

	////////////////////////////////////////////////////////////////////////////
	// Pin input synchroniser

	ppcs_sync #(
		.WIDTH(PPCS_PORT_W)
	) u_sync (
		.CORE_CLK(CORE_CLK),
		.RST_B   (RST_B),
		.ASYNC_IN(PIN_IN),
		.SYNC_OUT(pin_level)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	logic       emu_on;
	logic       unmapped;
	logic       hit_data;
	logic       hit_dir;
	logic       stretch_hold;
	logic       cs_gap;
	logic       ecs_level;
	logic       xcs_level;
	logic [7:0] gpio_read;
	logic [7:0] rd_value;

	always_comb begin
		next_state = state;

		emu_on   = state.page_emulation_enable;
		// Direction and data leave the map; the access goes out instead
		unmapped = emu_on && state.expanded_mode;
		hit_data = (ADDR == PPCS_OFS_DATA) && !unmapped;
		hit_dir  = (ADDR == PPCS_OFS_DIR) && !unmapped;

		// Register writes
		if (WR) begin
			if (hit_data) begin
				next_state.page_port_data = WDATA;
			end
			if (hit_dir) begin
				next_state.page_port_direction = WDATA;
			end
			if (ADDR == PPCS_OFS_PULL) begin
				next_state.page_port_pull_enable = WDATA[PPCS_BIT_PULL_EN];
			end
			if (ADDR == PPCS_OFS_BUSCTL) begin
				next_state.e_stretch_enable = WDATA[PPCS_BIT_STRETCH];
			end
			if (ADDR == PPCS_OFS_MODE) begin
				next_state.page_emulation_enable = WDATA[PPCS_BIT_EMU_EN];
				next_state.expanded_mode         = WDATA[PPCS_BIT_EXPANDED];
			end
		end

		// Output pins show the latch, input pins the synchronised level
		gpio_read = (state.page_port_direction & state.page_port_data)
			| (~state.page_port_direction & pin_level);

		rd_value = 8'h00;
		case (ADDR)
			PPCS_OFS_DATA: begin
				if (!unmapped) begin
					rd_value = gpio_read;
				end
			end
			PPCS_OFS_DIR: begin
				if (!unmapped) begin
					rd_value = state.page_port_direction;
				end
			end
			PPCS_OFS_PULL: begin
				rd_value[PPCS_BIT_PULL_EN] = state.page_port_pull_enable;
			end
			PPCS_OFS_BUSCTL: begin
				rd_value[PPCS_BIT_STRETCH] = state.e_stretch_enable;
			end
			PPCS_OFS_MODE: begin
				rd_value[PPCS_BIT_EMU_EN]   = state.page_emulation_enable;
				rd_value[PPCS_BIT_EXPANDED] = state.expanded_mode;
			end
			default: begin
				rd_value = 8'h00;
			end
		endcase
		// Read data stands for exactly one cycle
		next_state.rdata = RD ? rd_value : 8'h00;

		// Echo of unmapped accesses onto the external bus
		next_state.echo_wr    = WR && unmapped
			&& (ADDR == PPCS_OFS_DATA || ADDR == PPCS_OFS_DIR);
		next_state.echo_rd    = RD && unmapped
			&& (ADDR == PPCS_OFS_DATA || ADDR == PPCS_OFS_DIR);
		next_state.echo_addr  = ADDR;
		next_state.echo_wdata = WR ? WDATA : 8'h00;

		////////////////////////////////////////////////////////////////////////
		// Bus phase clock: low two quarters, high two quarters

		// Stretch only acts on an external bus
		stretch_hold = state.e_stretch_enable && state.expanded_mode
			&& STRETCH_REQ;
		case (state.phase)
			PPCS_PH_LOW0: begin
				next_state.phase = PPCS_PH_LOW1;
			end
			PPCS_PH_LOW1: begin
				next_state.phase = PPCS_PH_HIGH0;
			end
			PPCS_PH_HIGH0: begin
				next_state.phase = PPCS_PH_HIGH1;
			end
			PPCS_PH_HIGH1: begin
				if (stretch_hold) begin
					next_state.phase = PPCS_PH_HIGH1;
				end else begin
					next_state.phase = PPCS_PH_LOW0;
				end
			end
			default: begin
				next_state.phase = PPCS_PH_LOW0;
			end
		endcase
		next_state.e_clk = (next_state.phase == PPCS_PH_HIGH0)
			|| (next_state.phase == PPCS_PH_HIGH1);

		////////////////////////////////////////////////////////////////////////
		// Pin drive

		// First quarter after E falls, unless STRETCH_REQ is high while stretch is disabled
		cs_gap = (next_state.phase == PPCS_PH_LOW0)
			&& !(STRETCH_REQ && !state.e_stretch_enable);
		// Selects are active low; the gap forces the idle high level
		ecs_level = !EMULATION_CHIP_SELECT_REQ || cs_gap;
		xcs_level = !EXTERNAL_CHIP_SELECT_REQ || cs_gap;

		if (emu_on) begin
			next_state.pin_out[PPCS_BIT_ECS] = ecs_level;
			next_state.pin_out[PPCS_BIT_XCS] = xcs_level;
			next_state.pin_out[PPCS_PAGE_W-1:0] = EXPANDED_PAGE_ADDRESS_BITS;
			next_state.pin_oe = 8'hFF;
		end else begin
			// Every pin is general purpose, direction decides
			next_state.pin_out = state.page_port_data;
			next_state.pin_oe  = state.page_port_direction;
		end

		// Pulls only on pins that are inputs
		next_state.pin_pull = state.page_port_pull_enable
			? ~next_state.pin_oe : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state.page_port_data        <= PPCS_RST_DATA;
			state.page_port_direction   <= PPCS_RST_DIR;
			state.page_port_pull_enable <= PPCS_RST_PULL_EN;
			// Stretch on so a slow external reset vector still works
			state.e_stretch_enable      <= PPCS_RST_STRETCH;
			state.page_emulation_enable <= PPCS_RST_EMU_EN;
			state.expanded_mode         <= PPCS_RST_EXPAND;
			state.phase                 <= PPCS_PH_LOW0;
			state.e_clk                 <= 1'h0;
			state.rdata                 <= 8'h00;
			state.pin_out               <= 8'h00;
			state.pin_oe                <= 8'h00;
			state.pin_pull              <= 8'h00;
			state.echo_wr               <= 1'h0;
			state.echo_rd               <= 1'h0;
			state.echo_addr             <= '0;
			state.echo_wdata            <= 8'h00;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign RDATA           = state.rdata;
	assign PIN_OUT         = state.pin_out;
	assign PIN_OE          = state.pin_oe;
	assign PIN_PULL        = state.pin_pull;
	assign BUS_PHASE_CLOCK = state.e_clk;
	assign ECHO_WR         = state.echo_wr;
	assign ECHO_RD         = state.echo_rd;
	assign ECHO_ADDR       = state.echo_addr;
	assign ECHO_WDATA      = state.echo_wdata;

endmodule

// *** verif/ppcs_port_props.sv ***
// Checker for page port pins, register map and chip selects
`timescale 1ns/1ns
module ppcs_port_props (
	input wire logic       CORE_CLK,
	input wire logic       RST_B,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic [7:0] PIN_OUT,
	input wire logic [7:0] PIN_OE,
	input wire logic [7:0] PIN_PULL,
	input wire logic [5:0] EXPANDED_PAGE_ADDRESS_BITS,
	input wire logic       EMULATION_CHIP_SELECT_REQ,
	input wire logic       EXTERNAL_CHIP_SELECT_REQ,
	input wire logic       STRETCH_REQ,
	input wire logic       BUS_PHASE_CLOCK,
	input wire logic       ECHO_WR,
	input wire logic       ECHO_RD,
	input wire logic [2:0] ECHO_ADDR,
	input wire logic [7:0] ECHO_WDATA
);
	logic [7:0] dt;
	logic [7:0] dr;
	logic       pu, se, em, xp;
	wire        mapped = !(em && xp);
	////////////////////////////////////////////////////////////////
	// Shadow of the registers, rebuilt from bus writes
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			{dt, dr, pu, se, em, xp} <= 20'h00004;
		end else if (WR) begin
			case (ADDR)
				3'h0: if (mapped) dt <= WDATA;
				3'h1: if (mapped) dr <= WDATA;
				3'h2: pu <= WDATA[7];
				3'h3: se <= WDATA[0];
				3'h4: {em, xp} <= {WDATA[7], WDATA[0]};
				default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);
	gpio_pins_a: assert property (!$past(em) |-> PIN_OE == $past(dr) && PIN_OUT == $past(dt))
		else $error("Pins differ from direction and data");
	read_source_a: assert property (RD && ADDR == 3'h0 && !em |=> (RDATA & PIN_OE) == (PIN_OUT & PIN_OE))
		else $error("Output bits not read from latch");
	unmap_write_a: assert property (WR && ADDR < 3'h2 && !mapped |=> ECHO_WR && ECHO_ADDR == $past(ADDR))
		else $error("Unmapped write not echoed");
	echo_data_a: assert property (WR |=> ECHO_WDATA == $past(WDATA))
		else $error("Echoed write data wrong");
	unmap_read_a: assert property (RD && ADDR < 3'h2 && !mapped |=> ECHO_RD && RDATA == 8'h00)
		else $error("Unmapped read not echoed");
	mapped_quiet_a: assert property (RD && ADDR < 3'h2 && mapped |=> !ECHO_RD)
		else $error("Mapped read echoed");
	pull_pins_a: assert property (PIN_PULL == ($past(pu) ? ~PIN_OE : 8'h00))
		else $error("Pull pattern wrong");
	emu_selects_a: assert property ($past(em) && BUS_PHASE_CLOCK |-> PIN_OE == 8'hFF && PIN_OUT[7:6] == ~{$past(EMULATION_CHIP_SELECT_REQ), $past(EXTERNAL_CHIP_SELECT_REQ)})
		else $error("Chip selects wrong");
	page_bits_a: assert property ($past(em) |-> PIN_OUT[5:0] == $past(EXPANDED_PAGE_ADDRESS_BITS))
		else $error("Page bits wrong");
	cs_gap_a: assert property ($past(em) && $past(se) && $fell(BUS_PHASE_CLOCK) |-> PIN_OUT[7:6] == 2'b11)
		else $error("Selects not released after fall");
	free_run_a: assert property (!se && $rose(BUS_PHASE_CLOCK) |=> BUS_PHASE_CLOCK ##1 !BUS_PHASE_CLOCK)
		else $error("Phase clock stretched");
	stretch_hold_a: assert property (se && xp && STRETCH_REQ && BUS_PHASE_CLOCK && $past(BUS_PHASE_CLOCK) |=> BUS_PHASE_CLOCK)
		else $error("Phase clock not stretched");
	cover property (ECHO_WR);
	cover property (BUS_PHASE_CLOCK [*3]);
	cover property ($past(em) && $fell(BUS_PHASE_CLOCK));
endmodule

bind ppcs_port ppcs_port_props u_props (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
	.PIN_PULL(PIN_PULL), .EXPANDED_PAGE_ADDRESS_BITS(EXPANDED_PAGE_ADDRESS_BITS),
	.EMULATION_CHIP_SELECT_REQ(EMULATION_CHIP_SELECT_REQ), .STRETCH_REQ(STRETCH_REQ),
	.EXTERNAL_CHIP_SELECT_REQ(EXTERNAL_CHIP_SELECT_REQ), .BUS_PHASE_CLOCK(BUS_PHASE_CLOCK),
	.ECHO_WR(ECHO_WR), .ECHO_RD(ECHO_RD), .ECHO_ADDR(ECHO_ADDR), .ECHO_WDATA(ECHO_WDATA));

// *** verif/ppcs_far_model.sv ***
// Far side of the port pins: external driver, pull-ups, floating lines
`timescale 1ns/1ns
module ppcs_far_model (
	input  wire logic       clk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pull,
	input  wire logic [7:0] drive_en,
	input  wire logic [7:0] drive_val,
	output logic      [7:0] pin_level
);
	logic [7:0] churn = 8'h55;
	// Undriven, unpulled lines keep changing so no stale value is mistaken for a read
	always @(posedge clk) churn <= ~churn;
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & drive_en & drive_val)
		| (~pin_oe & ~drive_en & (pin_pull | churn));
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the page port
`timescale 1ns/1ns
module tb;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [5:0] page = 6'h00;
	logic       emulation_chip_select = 1'b0, xcs = 1'b0, str = 1'b0;
	logic [7:0] den = 8'h00, dval = 8'h00;
	logic [7:0] rdata, pin_in, pin_out, pin_oe, pin_pull, dir, dat, v;
	logic       echo_wr, echo_rd, ew, er;
	int         failures = 0;
	int         compares = 0;
	always #5 clk = ~clk;
	ppcs_port u_dut (.CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.PIN_PULL(pin_pull), .EXPANDED_PAGE_ADDRESS_BITS(page), .EMULATION_CHIP_SELECT_REQ(emulation_chip_select),
		.EXTERNAL_CHIP_SELECT_REQ(xcs), .STRETCH_REQ(str), .BUS_PHASE_CLOCK(),
		.ECHO_WR(echo_wr), .ECHO_RD(echo_rd), .ECHO_ADDR(), .ECHO_WDATA());
	ppcs_far_model u_far (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull(pin_pull),
		.drive_en(den), .drive_val(dval), .pin_level(pin_in));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] port_read(input logic [7:0] d, o, p);
		return (d & o) | (~d & p);
	endfunction
	task automatic chk(input logic [7:0] seen, exp, input string what);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
		ew = echo_wr;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input string what);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		er = echo_rd;
		chk(rdata, exp, what);
		@(posedge clk);
	endtask
	task automatic spin;
		repeat (12) begin
			{page, emulation_chip_select, xcs, str} <= 9'($urandom);
			@(posedge clk);
		end
	endtask
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		failures++;
		final_report();
	end
	initial begin
		void'($urandom(32'h7a8e4e88));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rd_reg(3'h1, 8'h00, "dir reset");
		chk(pin_oe, 8'h00, "oe reset");
		rd_reg(3'h3, 8'h01, "busctl reset");
		rd_reg(3'h5, 8'h00, "unmapped");
		for (int i = 0; i < 8; i++) begin
			dat = 8'($urandom);
			dir = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			v = 8'($urandom);
			wr_reg(3'h0, dat);
			wr_reg(3'h1, dir);
			den <= 8'hFF;
			dval <= v;
			// Pin filter needs several cycles before a new level reads back
			repeat (6) @(posedge clk);
			chk(pin_oe, dir, "oe");
			rd_reg(3'h0, port_read(dir, dat, v), "data");
		end
		den <= 8'h00;
		wr_reg(3'h2, 8'h80);
		wr_reg(3'h1, 8'h0F);
		repeat (6) @(posedge clk);
		chk(pin_pull, 8'hF0, "pull");
		rd_reg(3'h0, port_read(8'h0F, dat, 8'hFF), "pulled");
		wr_reg(3'h2, 8'h00);
		@(negedge clk);
		chk(pin_pull, 8'h00, "no pull");
		wr_reg(3'h4, 8'h80);
		spin();
		@(negedge clk);
		chk(pin_oe, 8'hFF, "emu oe");
		chk({2'h0, pin_out[5:0]}, {2'h0, page}, "page");
		wr_reg(3'h4, 8'h81);
		spin();
		wr_reg(3'h0, ~dat);
		chk({7'h00, ew}, 8'h01, "echo wr");
		rd_reg(3'h1, 8'h00, "unmapped dir");
		chk({7'h00, er}, 8'h01, "echo rd");
		wr_reg(3'h3, 8'h00);
		spin();
		wr_reg(3'h4, 8'h00);
		@(negedge clk);
		chk(pin_out, dat, "data kept");
		chk(pin_oe, 8'h0F, "gpio again");
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_reg(3'h1, 8'h00, "dir rereset");
		chk(pin_oe, 8'h00, "oe rereset");
		final_report();
	end
endmodule
